/* File: core/tcsp_pkg.sv */
// constants, types and register map of the five-channel timer unit
// assumes a single AHB-Lite master and one 100 MHz clock
`default_nettype none
package tcsp_pkg;
	// ==========================================
	// sizes
	localparam int NCH = 5;
	localparam int CW = 16;
	localparam int NFLAG = 3;
	localparam int NPH = 3;
	localparam int CH_P0 = 3;
	localparam int CH_P1 = 4;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] OFS_START = 8'h00;
	localparam logic [7:0] OFS_SYNC = 8'h04;
	localparam logic [7:0] OFS_PWM = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0C;
	localparam logic [7:0] OFS_FLAG = 8'h10;
	localparam logic [7:0] OFS_IEN = 8'h14;
	localparam logic [2:0] CH_BASE_IDX = 3'h1;
	localparam logic [4:0] FLD_CTL = 5'h00;
	localparam logic [4:0] FLD_CNT = 5'h04;
	localparam logic [4:0] FLD_GRA = 5'h08;
	localparam logic [4:0] FLD_GRB = 5'h0C;
	localparam logic [4:0] FLD_BUFA = 5'h10;
	localparam logic [4:0] FLD_BUFB = 5'h14;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam int MODE_BUF_BIT = 2;
	// ==========================================
	// flag layout per channel, reset values
	localparam int FL_A = 0;
	localparam int FL_B = 1;
	localparam int FL_OVF = 2;
	localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;
	localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CW-1:0] GR_RST = 16'hFFFF;
	// ==========================================
	// types
	typedef enum logic [1:0] {MODE_NORMAL = 2'b00, MODE_RSYNC = 2'b01,
		MODE_COMPL = 2'b10} tcsp_mode_e;
	typedef enum logic [1:0] {CLR_NONE = 2'b00, CLR_A = 2'b01, CLR_B = 2'b10,
		CLR_SYNC = 2'b11} tcsp_clr_e;
	typedef enum logic [1:0] {EDGE_NONE = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11} tcsp_edge_e;
	typedef struct packed {
		tcsp_edge_e edge_b;
		tcsp_edge_e edge_a;
		tcsp_clr_e clr_src;
	} tcsp_chctl_s;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} tcsp_aphase_s;
endpackage : tcsp_pkg
`default_nettype wire

/* File: core/tcsp_timer.sv */
// five-channel 16-bit timer: capture, sync preset/clear, pwm, paired three-phase pwm
// assumes AHB-Lite single-slave bus, pins synchronous to hclk
`default_nettype none
module tcsp_timer (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// channel pins
	input wire logic [tcsp_pkg::NCH-1:0] chan_pin_a_in,
	output logic [tcsp_pkg::NCH-1:0] chan_pin_a_out,
	output logic [tcsp_pkg::NCH-1:0] chan_pin_a_oe_n,
	input wire logic [tcsp_pkg::NCH-1:0] chan_pin_b_in,
	output logic [tcsp_pkg::NCH-1:0] chan_pin_b_out,
	output logic [tcsp_pkg::NCH-1:0] chan_pin_b_oe_n,
	output logic ch4_extra_out_a,
	output logic ch4_extra_out_b,
	// status
	output logic irq_req
);
	localparam int N = tcsp_pkg::NCH;
	localparam int W = tcsp_pkg::CW;
	localparam int NF = N * tcsp_pkg::NFLAG;

	// ==========================================
	// bus slave
	tcsp_pkg::tcsp_aphase_s aph;
	logic wr;
	logic [2:0] ch_idx;
	logic [4:0] fld;
	logic [N-1:0] start, sync, pwm;
	tcsp_pkg::tcsp_mode_e mode;
	logic buf_en;
	logic [NF-1:0] flags, ien, set_v;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr = aph.valid && aph.write;
	assign ch_idx = aph.addr[7:5] - tcsp_pkg::CH_BASE_IDX;
	assign fld = aph.addr[4:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph <= '0;
		end else if (hready) begin
			aph.valid <= hsel && htrans[1] && (hsize == tcsp_pkg::SIZE_WORD);
			aph.write <= hwrite;
			aph.addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start <= '0;
			sync <= '0;
			pwm <= '0;
			mode <= tcsp_pkg::MODE_NORMAL;
			buf_en <= 1'b0;
			ien <= '0;
		end else if (wr) begin
			unique case (aph.addr)
				tcsp_pkg::OFS_START: start <= hwdata[N-1:0];
				tcsp_pkg::OFS_SYNC: sync <= hwdata[N-1:0];
				tcsp_pkg::OFS_PWM: pwm <= hwdata[N-1:0];
				tcsp_pkg::OFS_MODE: begin
					mode <= tcsp_pkg::tcsp_mode_e'(hwdata[1:0]);
					buf_en <= hwdata[tcsp_pkg::MODE_BUF_BIT];
				end
				tcsp_pkg::OFS_IEN: ien <= hwdata[NF-1:0];
				default: ;
			endcase
		end
	end

	// sticky flags, write one to clear, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= '0;
		end else if (wr && aph.addr == tcsp_pkg::OFS_FLAG) begin
			flags <= (flags & ~hwdata[NF-1:0]) | set_v;
		end else begin
			flags <= flags | set_v;
		end
	end

	assign irq_req = |(flags & ien);

	// ==========================================
	// channel state
	logic [W-1:0] cnt [N];
	logic [W-1:0] general_reg_a [N];
	logic [W-1:0] general_reg_b [N];
	logic [W-1:0] bufa [N];
	logic [W-1:0] bufb [N];
	tcsp_pkg::tcsp_chctl_s ctl [N];
	logic [N-1:0] ch_sel, match_a, match_b, cap_a, cap_b, a_cap, b_cap;
	logic [N-1:0] ev_a, ev_b, clr_own, do_clr, cnt_load, prev_a, prev_b;
	logic rs, cp, dir_down, turn_dn, uf4, sync_clr, sync_wr, buf_xfer;
	logic [tcsp_pkg::NPH-1:0] next_p, next_q, cur_p;

	assign rs = (mode == tcsp_pkg::MODE_RSYNC);
	assign cp = (mode == tcsp_pkg::MODE_COMPL);
	assign sync_clr = |(clr_own & sync);
	assign sync_wr = wr && fld == tcsp_pkg::FLD_CNT && |(ch_sel & sync);
	assign turn_dn = cp && start[tcsp_pkg::CH_P0] && !dir_down && match_a[tcsp_pkg::CH_P0];
	assign uf4 = cp && start[tcsp_pkg::CH_P1] && dir_down
		&& cnt[tcsp_pkg::CH_P1] == tcsp_pkg::CNT_ZERO;
	assign buf_xfer = buf_en && ((rs && start[tcsp_pkg::CH_P0]
		&& match_a[tcsp_pkg::CH_P0]) || turn_dn || uf4);

	// shared count direction of the paired counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_down <= 1'b0;
		end else if (!cp) begin
			dir_down <= 1'b0;
		end else if (turn_dn) begin
			dir_down <= 1'b1;
		end else if (uf4) begin
			dir_down <= 1'b0;
		end
	end

	genvar n;
	generate
		for (n = 0; n < N; n++) begin : g_ch
			localparam bit PAIRED = (n >= tcsp_pkg::CH_P0);
			localparam int PI = PAIRED ? n - tcsp_pkg::CH_P0 : 0;
			logic outm, updn, rise_a, fall_a, rise_b, fall_b;
			assign outm = pwm[n] || (PAIRED && (rs || cp));
			assign updn = PAIRED && cp;
			assign ch_sel[n] = (aph.addr[7:5] == 3'(n + 1));
			assign rise_a = chan_pin_a_in[n] && !prev_a[n];
			assign fall_a = !chan_pin_a_in[n] && prev_a[n];
			assign rise_b = chan_pin_b_in[n] && !prev_b[n];
			assign fall_b = !chan_pin_b_in[n] && prev_b[n];
			assign a_cap[n] = ctl[n].edge_a != tcsp_pkg::EDGE_NONE && !outm;
			assign b_cap[n] = ctl[n].edge_b != tcsp_pkg::EDGE_NONE && !outm;
			assign cap_a[n] = a_cap[n] && ((ctl[n].edge_a[0] && rise_a)
				|| (ctl[n].edge_a[1] && fall_a));
			assign cap_b[n] = b_cap[n] && ((ctl[n].edge_b[0] && rise_b)
				|| (ctl[n].edge_b[1] && fall_b));
			// equality seen now acts at this edge, as the count leaves it
			assign match_a[n] = cnt[n] == general_reg_a[n] && !(rs && n == tcsp_pkg::CH_P1);
			assign match_b[n] = cnt[n] == general_reg_b[n] && !(rs && n == tcsp_pkg::CH_P1);
			assign ev_a[n] = a_cap[n] ? cap_a[n] : start[n] && match_a[n];
			assign ev_b[n] = b_cap[n] ? cap_b[n] : start[n] && match_b[n];
			assign clr_own[n] = (ctl[n].clr_src == tcsp_pkg::CLR_A && ev_a[n])
				|| (ctl[n].clr_src == tcsp_pkg::CLR_B && ev_b[n]);
			assign do_clr[n] = updn ? 1'b0
				: (rs && n == tcsp_pkg::CH_P0) ? match_a[n]
				: clr_own[n] || (ctl[n].clr_src == tcsp_pkg::CLR_SYNC
				&& sync[n] && sync_clr);
			assign cnt_load[n] = wr && fld == tcsp_pkg::FLD_CNT
				&& (ch_sel[n] || (sync[n] && sync_wr));
			assign set_v[n*tcsp_pkg::NFLAG+tcsp_pkg::FL_A] = ev_a[n]
				&& !(cp && n == tcsp_pkg::CH_P0 && dir_down);
			assign set_v[n*tcsp_pkg::NFLAG+tcsp_pkg::FL_B] = ev_b[n];
			assign set_v[n*tcsp_pkg::NFLAG+tcsp_pkg::FL_OVF] = updn
				? (n == tcsp_pkg::CH_P1 && uf4)
				: start[n] && !do_clr[n] && cnt[n] == tcsp_pkg::CNT_MAX;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					prev_a[n] <= 1'b0;
					prev_b[n] <= 1'b0;
				end else begin
					prev_a[n] <= chan_pin_a_in[n];
					prev_b[n] <= chan_pin_b_in[n];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt[n] <= tcsp_pkg::CNT_ZERO;
				end else if (cnt_load[n]) begin
					cnt[n] <= hwdata[W-1:0];
				end else if (start[n]) begin
					if (do_clr[n]) begin
						cnt[n] <= tcsp_pkg::CNT_ZERO;
					end else if (updn && dir_down) begin
						cnt[n] <= cnt[n] - tcsp_pkg::CNT_ONE;
					end else begin
						cnt[n] <= cnt[n] + tcsp_pkg::CNT_ONE;
					end
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ctl[n] <= '0;
					bufa[n] <= tcsp_pkg::GR_RST;
					bufb[n] <= tcsp_pkg::GR_RST;
				end else if (wr && ch_sel[n]) begin
					unique case (fld)
						tcsp_pkg::FLD_CTL: ctl[n] <= hwdata[5:0];
						tcsp_pkg::FLD_BUFA: bufa[n] <= hwdata[W-1:0];
						tcsp_pkg::FLD_BUFB: bufb[n] <= hwdata[W-1:0];
						default: ;
					endcase
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					general_reg_a[n] <= tcsp_pkg::GR_RST;
				end else if (wr && ch_sel[n] && fld == tcsp_pkg::FLD_GRA) begin
					general_reg_a[n] <= hwdata[W-1:0];
				end else if (cap_a[n]) begin
					general_reg_a[n] <= cnt[n];
				end else if (PAIRED && buf_xfer) begin
					general_reg_a[n] <= bufa[n];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					general_reg_b[n] <= tcsp_pkg::GR_RST;
				end else if (wr && ch_sel[n] && fld == tcsp_pkg::FLD_GRB) begin
					general_reg_b[n] <= hwdata[W-1:0];
				end else if (cap_b[n]) begin
					general_reg_b[n] <= cnt[n];
				end else if (PAIRED && buf_xfer) begin
					general_reg_b[n] <= bufb[n];
				end
			end

			// pin A: plain pwm, or primary of a phase pair
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					chan_pin_a_out[n] <= 1'b0;
				end else if (PAIRED && (rs || cp)) begin
					chan_pin_a_out[n] <= next_p[PI];
				end else if (pwm[n] && ev_a[n] && !ev_b[n]) begin
					chan_pin_a_out[n] <= 1'b1;
				end else if (pwm[n] && ev_b[n] && !ev_a[n]) begin
					chan_pin_a_out[n] <= 1'b0;
				end
			end

			assign chan_pin_a_oe_n[n] = !outm;
			assign chan_pin_b_oe_n[n] = !(PAIRED && (rs || cp));

			a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
				cap_a[n] && !(wr && ch_sel[n] && fld == tcsp_pkg::FLD_GRA)
				|=> general_reg_a[n] == $past(cnt[n]))
				else $error("capture did not copy counter");
			a_capb_clear: assert property (@(posedge hclk) disable iff (!hresetn)
				cap_b[n] && start[n] && !updn && !cnt_load[n]
				&& ctl[n].clr_src == tcsp_pkg::CLR_B |=> cnt[n] == tcsp_pkg::CNT_ZERO)
				else $error("capture B did not clear counter");
			a_sync_preset: assert property (@(posedge hclk) disable iff (!hresetn)
				sync_wr && sync[n] |=> cnt[n] == $past(hwdata[W-1:0]))
				else $error("sync preset missed a channel");
			a_pwm_edges: assert property (@(posedge hclk) disable iff (!hresetn)
				pwm[n] && !(PAIRED && (rs || cp)) && ev_a[n] && !ev_b[n]
				##1 !ev_b[n] |-> chan_pin_a_out[n])
				else $error("pwm pin not high after match A");
			a_pwm_equal: assert property (@(posedge hclk) disable iff (!hresetn)
				pwm[n] && !(PAIRED && (rs || cp)) && ev_a[n] && ev_b[n]
				|=> $stable(chan_pin_a_out[n]))
				else $error("pwm pin moved on equal match");
		end
	endgenerate

	// ==========================================
	// three-phase pairs on channels 3 and 4
	logic [W-1:0] tp [tcsp_pkg::NPH];
	assign tp[0] = general_reg_b[tcsp_pkg::CH_P0];
	assign tp[1] = general_reg_a[tcsp_pkg::CH_P1];
	assign tp[2] = general_reg_b[tcsp_pkg::CH_P1];
	assign cur_p = {chan_pin_b_out[tcsp_pkg::CH_P1], chan_pin_a_out[tcsp_pkg::CH_P1],
		chan_pin_a_out[tcsp_pkg::CH_P0]};

	genvar k;
	generate
		for (k = 0; k < tcsp_pkg::NPH; k++) begin : g_ph
			always_comb begin
				next_p[k] = 1'b0;
				next_q[k] = 1'b0;
				if (rs) begin
					next_p[k] = cur_p[k];
					if (start[tcsp_pkg::CH_P0] && do_clr[tcsp_pkg::CH_P0]) begin
						next_p[k] = 1'b1;
					end else if (start[tcsp_pkg::CH_P0] && cnt[tcsp_pkg::CH_P0] == tp[k]) begin
						next_p[k] = 1'b0;
					end
					next_q[k] = !next_p[k];
				end else if (cp) begin
					// lower counter decides primary, upper decides partner
					// undershoot of the lower counter must not raise the primary
					next_p[k] = cnt[tcsp_pkg::CH_P1] > tp[k]
						&& cnt[tcsp_pkg::CH_P1] < cnt[tcsp_pkg::CH_P0];
					next_q[k] = cnt[tcsp_pkg::CH_P0] <= tp[k];
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_pin_b_out <= '0;
			ch4_extra_out_a <= 1'b0;
			ch4_extra_out_b <= 1'b0;
		end else begin
			chan_pin_b_out <= '0;
			chan_pin_b_out[tcsp_pkg::CH_P0] <= next_q[0];
			chan_pin_b_out[tcsp_pkg::CH_P1] <= next_p[2];
			ch4_extra_out_a <= next_q[1];
			ch4_extra_out_b <= next_q[2];
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		hrdata = '0;
		if (aph.valid && !aph.write) begin
			unique case (aph.addr)
				tcsp_pkg::OFS_START: hrdata[N-1:0] = start;
				tcsp_pkg::OFS_SYNC: hrdata[N-1:0] = sync;
				tcsp_pkg::OFS_PWM: hrdata[N-1:0] = pwm;
				tcsp_pkg::OFS_MODE: hrdata[2:0] = {buf_en, mode};
				tcsp_pkg::OFS_FLAG: hrdata[NF-1:0] = flags;
				tcsp_pkg::OFS_IEN: hrdata[NF-1:0] = ien;
				default: begin
					if (ch_idx < 3'(N)) begin
						unique case (fld)
							tcsp_pkg::FLD_CTL: hrdata[5:0] = ctl[ch_idx];
							tcsp_pkg::FLD_CNT: hrdata[W-1:0] = cnt[ch_idx];
							tcsp_pkg::FLD_GRA: hrdata[W-1:0] = general_reg_a[ch_idx];
							tcsp_pkg::FLD_GRB: hrdata[W-1:0] = general_reg_b[ch_idx];
							tcsp_pkg::FLD_BUFA: hrdata[W-1:0] = bufa[ch_idx];
							tcsp_pkg::FLD_BUFB: hrdata[W-1:0] = bufb[ch_idx];
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// ==========================================
	// paired-mode checks
	a_rs_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		rs && start[3] && match_a[3] && !cnt_load[3] |=> cnt[3] == tcsp_pkg::CNT_ZERO)
		else $error("reset-sync counter not cleared at period");
	a_no_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
		cp |=> !(chan_pin_a_out[3] && chan_pin_b_out[3])
		&& !(chan_pin_a_out[4] && ch4_extra_out_a) && !(chan_pin_b_out[4] && ch4_extra_out_b))
		else $error("complementary pair overlap");
	a_dir_turn: assert property (@(posedge hclk) disable iff (!hresetn)
		turn_dn ##1 cp |-> dir_down)
		else $error("no turn to down count");
	a_buf_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		rs && buf_en && start[3] && match_a[3] && !wr |=> general_reg_b[3] == $past(bufb[3]))
		else $error("buffer not transferred");
endmodule : tcsp_timer
`default_nettype wire

/* File: tb/tcsp_far_end.sv */
// far side of the timer pins: pulse source on the capture inputs
// assumes the timer's pin drive and enables, and the bench clock hclk
`default_nettype none
module tcsp_far_end (
	// clock
	input wire logic hclk,
	// timer pin drive
	input wire logic [tcsp_pkg::NCH-1:0] pin_a_out,
	input wire logic [tcsp_pkg::NCH-1:0] pin_a_oe_n,
	input wire logic [tcsp_pkg::NCH-1:0] pin_b_out,
	input wire logic [tcsp_pkg::NCH-1:0] pin_b_oe_n,
	// resolved pin levels
	output logic [tcsp_pkg::NCH-1:0] pin_a,
	output logic [tcsp_pkg::NCH-1:0] pin_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [tcsp_pkg::NCH-1:0] src_a = '0;
	logic [tcsp_pkg::NCH-1:0] src_b = '0;
	// ==========================================
	// wire level: timer wins where it drives
	assign pin_a = (pin_a_out & ~pin_a_oe_n) | (src_a & pin_a_oe_n);
	assign pin_b = (pin_b_out & ~pin_b_oe_n) | (src_b & pin_b_oe_n);
	// ==========================================
	// one level change, held at least three clocks
	task automatic step(input logic sel_b, input int ch, input logic lvl, input int hold);
		@(posedge hclk);
		if (sel_b) begin
			src_b[ch] <= lvl;
		end else begin
			src_a[ch] <= lvl;
		end
		repeat ((hold < 3) ? 3 : hold) @(posedge hclk);
	endtask : step
endmodule : tcsp_far_end
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the timer unit, registers over ahb-lite
// assumes tcsp_pkg, tcsp_timer and tcsp_far_end compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp, xa, xb, irq;
	logic [31:0] hrdata, v, w;
	logic [4:0] pa, pb, ao, aoe, bo, boe;
	int n_mismatch = 0;
	int samples_checked = 0;
	int h2, h3, h4a, h4b, inv, ovl;
	logic [1:0] t_clr [4] = '{2'h2, 2'h2, 2'h1, 2'h1};
	logic [15:0] t_ga [4] = '{16'h0004, 16'h000A, 16'h0008, 16'h0008};
	logic [15:0] t_gb [4] = '{16'h0008, 16'h0008, 16'h000A, 16'h0008};
	int t_hi [4] = '{16, 0, 36, 36};
	always #5 hclk = ~hclk;
	tcsp_timer tcsp_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.chan_pin_a_in(pa), .chan_pin_a_out(ao), .chan_pin_a_oe_n(aoe),
		.chan_pin_b_in(pb), .chan_pin_b_out(bo), .chan_pin_b_oe_n(boe),
		.ch4_extra_out_a(xa), .ch4_extra_out_b(xb), .irq_req(irq));
	tcsp_far_end tcsp_far_end_i (.hclk(hclk), .pin_a_out(ao), .pin_a_oe_n(aoe),
		.pin_b_out(bo), .pin_b_oe_n(boe), .pin_a(pa), .pin_b(pb));
	// ==========================================
	// verdict
	task automatic close_out();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// ==========================================
	// bus access: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= tcsp_pkg::SIZE_WORD;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		r = hrdata;
		if (k >= 64) begin
			n_mismatch++;
			close_out();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h00000000, r);
	endtask : rd
	function automatic logic [7:0] ca(input int n, input logic [4:0] f);
		return 8'(32'h20 * (n + 1)) | {3'h0, f};
	endfunction : ca
	// ==========================================
	// pin watch over n clocks
	task automatic watch(input int n);
		h2 = 0;
		h3 = 0;
		h4a = 0;
		h4b = 0;
		inv = 0;
		ovl = 0;
		repeat (n) begin
			@(posedge hclk);
			h2 += int'(pa[2]);
			h3 += int'(pa[3]);
			h4a += int'(pa[4]);
			h4b += int'(pb[4]);
			inv += int'(pa[3] === pb[3] || pa[4] === xa || pb[4] === xb);
			ovl += int'((pa[3] & pb[3]) === 1'b1 || (pa[4] & xa) === 1'b1
				|| (pb[4] & xb) === 1'b1);
		end
	endtask : watch
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ca(0, tcsp_pkg::FLD_GRA), v);
		chk("gra reset", 32'h0000FFFF, v);
		wr(8'hFC, 32'hFFFFFFFF);
		rd(8'hFC, v);
		chk("unmapped", 32'h00000000, v);
		chk("hresp", 32'h00000000, {31'h0, hresp});
		// capture on pin A, every edge code but EDGE_NONE
		wr(tcsp_pkg::OFS_IEN, 32'h00000001);
		wr(ca(0, tcsp_pkg::FLD_GRA), 32'h00000000);
		w = 32'h00000000;
		for (int e = 1; e < 4; e++) begin
			wr(ca(0, tcsp_pkg::FLD_CTL), 32'(e) << 2);
			wr(ca(0, tcsp_pkg::FLD_CNT), 32'h00001110 + 32'(e));
			tcsp_far_end_i.step(1'b0, 0, 1'b1, 3);
			if (e != 2) w = 32'h00001110 + 32'(e);
			rd(ca(0, tcsp_pkg::FLD_GRA), v);
			chk("capture rise", w, v);
			wr(ca(0, tcsp_pkg::FLD_CNT), 32'h00002220 + 32'(e));
			tcsp_far_end_i.step(1'b0, 0, 1'b0, 5);
			if (e != 1) w = 32'h00002220 + 32'(e);
			rd(ca(0, tcsp_pkg::FLD_GRA), v);
			chk("capture fall", w, v);
		end
		chk("irq set", 32'h00000001, {31'h0, irq});
		rd(tcsp_pkg::OFS_FLAG, v);
		chk("flag a", 32'h00000001, v & 32'h00000007);
		wr(tcsp_pkg::OFS_FLAG, 32'h00000001);
		@(negedge hclk);
		chk("irq clear", 32'h00000000, {31'h0, irq});
		@(posedge hclk);
		// falling capture on pin B clears a running counter
		wr(ca(0, tcsp_pkg::FLD_CTL), 32'h00000022);
		wr(ca(0, tcsp_pkg::FLD_CNT), 32'h00004000);
		wr(tcsp_pkg::OFS_START, 32'h00000001);
		tcsp_far_end_i.step(1'b1, 0, 1'b1, 3);
		tcsp_far_end_i.step(1'b1, 0, 1'b0, 3);
		rd(ca(0, tcsp_pkg::FLD_CNT), v);
		chk("clear on b", 32'h00000001, {31'h0, v < 32'h00000020});
		rd(ca(0, tcsp_pkg::FLD_GRB), v);
		chk("capture b", 32'h00000001, {31'h0, v[15:8] == 8'h40});
		wr(tcsp_pkg::OFS_START, 32'h00000000);
		// synchronous preset and clear
		wr(tcsp_pkg::OFS_SYNC, 32'h00000013);
		wr(ca(1, tcsp_pkg::FLD_CNT), 32'h00001234);
		for (int c = 0; c < 5; c++) begin
			rd(ca(c, tcsp_pkg::FLD_CNT), v);
			chk("sync preset", (c == 2 || c == 3) ? 32'h0 : 32'h00001234, v);
		end
		wr(ca(0, tcsp_pkg::FLD_GRA), 32'h00000010);
		wr(ca(0, tcsp_pkg::FLD_CTL), 32'h00000001);
		wr(ca(1, tcsp_pkg::FLD_CTL), 32'h00000003);
		wr(ca(1, tcsp_pkg::FLD_CNT), 32'h00000000);
		wr(tcsp_pkg::OFS_START, 32'h00000003);
		watch(40);
		wr(tcsp_pkg::OFS_START, 32'h00000000);
		rd(ca(1, tcsp_pkg::FLD_CNT), v);
		chk("sync clear", 32'h00000001, {31'h0, v <= 32'h00000010});
		wr(tcsp_pkg::OFS_SYNC, 32'h00000000);
		// pwm duty table on channel 2
		wr(tcsp_pkg::OFS_PWM, 32'h00000004);
		for (int i = 0; i < 4; i++) begin
			wr(tcsp_pkg::OFS_START, 32'h00000000);
			wr(ca(2, tcsp_pkg::FLD_CNT), 32'h00000000);
			wr(ca(2, tcsp_pkg::FLD_GRA), {16'h0000, t_ga[i]});
			wr(ca(2, tcsp_pkg::FLD_GRB), {16'h0000, t_gb[i]});
			wr(ca(2, tcsp_pkg::FLD_CTL), {30'h0, t_clr[i]});
			wr(tcsp_pkg::OFS_START, 32'h00000004);
			watch(12);
			watch(36);
			chk("pwm duty", 32'(t_hi[i]), 32'(h2));
		end
		chk("pwm oe", 32'h00000000, {31'h0, aoe[2]});
		wr(tcsp_pkg::OFS_START, 32'h00000000);
		wr(tcsp_pkg::OFS_PWM, 32'h00000000);
		// reset-synchronized pwm, buffered
		wr(ca(4, tcsp_pkg::FLD_CTL), 32'h00000001);
		wr(ca(3, tcsp_pkg::FLD_CNT), 32'h00000000);
		wr(ca(4, tcsp_pkg::FLD_CNT), 32'h00000000);
		wr(ca(3, tcsp_pkg::FLD_GRA), 32'h00000009);
		wr(ca(3, tcsp_pkg::FLD_GRB), 32'h00000002);
		wr(ca(4, tcsp_pkg::FLD_GRA), 32'h00000004);
		wr(ca(4, tcsp_pkg::FLD_GRB), 32'h00000006);
		wr(ca(3, tcsp_pkg::FLD_BUFA), 32'h00000009);
		wr(ca(3, tcsp_pkg::FLD_BUFB), 32'h00000003);
		wr(ca(4, tcsp_pkg::FLD_BUFA), 32'h00000004);
		wr(ca(4, tcsp_pkg::FLD_BUFB), 32'h00000006);
		wr(tcsp_pkg::OFS_MODE, 32'h00000005);
		wr(tcsp_pkg::OFS_START, 32'h00000018);
		watch(14);
		watch(30);
		chk("rs oe", 32'h00000000, {28'h0, aoe[4:3], boe[4:3]});
		chk("rs pair", 32'h00000000, 32'(inv));
		chk("rs ch3", 32'd12, 32'(h3));
		chk("rs ch4a", 32'd15, 32'(h4a));
		chk("rs ch4b", 32'd21, 32'(h4b));
		wr(tcsp_pkg::OFS_START, 32'h00000000);
		rd(ca(3, tcsp_pkg::FLD_GRB), v);
		chk("rs buffer", 32'h00000003, v);
		rd(ca(4, tcsp_pkg::FLD_CNT), v);
		chk("rs ch4 free", 32'h00000001, {31'h0, v > 32'h00000010});
		// complementary pwm
		wr(tcsp_pkg::OFS_MODE, 32'h00000002);
		wr(ca(4, tcsp_pkg::FLD_CTL), 32'h00000000);
		wr(ca(3, tcsp_pkg::FLD_CNT), 32'h00000002);
		wr(ca(4, tcsp_pkg::FLD_CNT), 32'h00000000);
		wr(ca(3, tcsp_pkg::FLD_GRA), 32'h00000014);
		wr(ca(3, tcsp_pkg::FLD_GRB), 32'h00000008);
		wr(ca(4, tcsp_pkg::FLD_GRA), 32'h0000000A);
		wr(ca(4, tcsp_pkg::FLD_GRB), 32'h0000000C);
		wr(tcsp_pkg::OFS_FLAG, 32'h00007FFF);
		wr(tcsp_pkg::OFS_START, 32'h00000018);
		watch(300);
		chk("cp overlap", 32'h00000000, 32'(ovl));
		chk("cp toggles", 32'h00000001, {31'h0, h3 > 0 && h3 < 300});
		rd(tcsp_pkg::OFS_FLAG, v);
		chk("cp flags", 32'h00004200, v & 32'h00004200);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
